/* rtl/stl_pkg.sv */
// shared constants and carriers for the bus timing supervisor
package stl_pkg;
  // clock rate in kHz
  localparam int unsigned SYS_CLK_KHZ      = 250000;
  // documented times
  localparam int unsigned CLK_LOW_TOUT_MS  = 35;
  localparam int unsigned IDLE_RESET_MS    = 50;
  localparam int unsigned STRETCH_MAX_MS   = 25;
  localparam int unsigned HIGH_MAX_US      = 50;
  localparam int unsigned BUS_FREQ_MIN_KHZ = 10;
  localparam int unsigned BUS_FREQ_MAX_KHZ = 400;
  // derived cycle counts (the microsecond time rounds down)
  localparam int unsigned CLK_LOW_TOUT_CYC = CLK_LOW_TOUT_MS * SYS_CLK_KHZ;
  localparam int unsigned IDLE_RESET_CYC   = IDLE_RESET_MS * SYS_CLK_KHZ;
  localparam int unsigned STRETCH_MAX_CYC  = STRETCH_MAX_MS * SYS_CLK_KHZ;
  localparam int unsigned HIGH_MAX_CYC     = (HIGH_MAX_US * SYS_CLK_KHZ) / 1000;
  localparam int unsigned CNT_W            = 24;
  // control reset value
  localparam logic NONSTD_RST = 1'h0;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_WAIT  = 2'b10
  } stl_state_e;

  // synchronised bus pin levels and derived events
  typedef struct packed {
    logic scl;
    logic sda;
    logic start;
    logic stop;
    logic scl_fall;
    logic scl_rise;
  } stl_bus_s;

  // supervisor status toward the protocol engine
  typedef struct packed {
    logic timeout;
    logic idle_reset;
    logic high_idle;
    logic stretch_allow;
    logic busy;
  } stl_stat_s;
endpackage

/* rtl/stl_pin_sync.sv */
`timescale 1ns/1ns
// two-stage synchroniser and edge finder for the bus pins
module stl_pin_sync
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // raw pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  // synchronised view
  output stl_pkg::stl_bus_s      bus_o
);
  typedef struct packed {
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic       scl_d;
    logic       sda_d;
    stl_pkg::stl_bus_s bus;
  } stl_sync_s;

  stl_sync_s state_ff;
  stl_sync_s nxt_state;

  // second stage alone feeds the edge logic
  always_comb
  begin
    nxt_state              = state_ff;
    nxt_state.scl_meta     = {state_ff.scl_meta[0], scl_i};
    nxt_state.sda_meta     = {state_ff.sda_meta[0], sda_i};
    nxt_state.scl_d        = state_ff.scl_meta[1];
    nxt_state.sda_d        = state_ff.sda_meta[1];
    nxt_state.bus.scl      = state_ff.scl_meta[1];
    nxt_state.bus.sda      = state_ff.sda_meta[1];
    nxt_state.bus.scl_fall = state_ff.scl_d & ~state_ff.scl_meta[1];
    nxt_state.bus.scl_rise = ~state_ff.scl_d & state_ff.scl_meta[1];
    // data moves while clock is high: start or stop
    nxt_state.bus.start    = state_ff.scl_d & state_ff.scl_meta[1] & state_ff.sda_d & ~state_ff.sda_meta[1];
    nxt_state.bus.stop     = state_ff.scl_d & state_ff.scl_meta[1] & ~state_ff.sda_d & state_ff.sda_meta[1];
  end

  // idle bus is high, so reset to high
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff     <= '0;
      state_ff.scl_meta <= 2'h3;
      state_ff.sda_meta <= 2'h3;
      state_ff.scl_d    <= 1'h1;
      state_ff.sda_d    <= 1'h1;
      state_ff.bus.scl  <= 1'h1;
      state_ff.bus.sda  <= 1'h1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign bus_o = state_ff.bus;
endmodule

/* rtl/stl_bus_supervisor.sv */
`timescale 1ns/1ns
// timing supervisor for the two-wire target interface
// Overview of operation
// - act as bus target; host clocks the bus between 10 and 400 kHz.
// - a clock low longer than 35 ms during a transfer gives a timeout and abandons the transfer.
// - clock and data both high over 50 ms reset any transaction in progress.
// - timeout and idle reset only act while nonstandard_bus_ctrl stays cleared.
// - total stretching from start to stop stays at or below 25 ms.
// - a clock high over 50 us counts as the bus going idle.
module stl_bus_supervisor
#(
  parameter int unsigned LOW_TOUT_CYC  = stl_pkg::CLK_LOW_TOUT_CYC,
  parameter int unsigned IDLE_CYC      = stl_pkg::IDLE_RESET_CYC,
  parameter int unsigned STRETCH_CYC   = stl_pkg::STRETCH_MAX_CYC,
  parameter int unsigned HIGH_MAX_CYC  = stl_pkg::HIGH_MAX_CYC
)
(
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              reset_n_i,
  // bus pins
  input  wire logic              bus_clock_pin_i,
  input  wire logic              bus_data_pin_i,
  output logic                   bus_clock_pin_o,
  output logic                   bus_clock_pin_oe_n_o,
  output logic                   bus_data_pin_o,
  output logic                   bus_data_pin_oe_n_o,
  // control
  input  wire logic              nonstandard_bus_ctrl_i,
  // protocol engine side
  input  wire logic              stretch_req_i,
  input  wire logic              sda_drive_low_i,
  output logic                   xfer_abort_o,
  output logic                   timeout_o,
  output logic                   idle_reset_o,
  output logic                   bus_idle_o,
  output logic                   busy_o
);
  localparam logic [stl_pkg::CNT_W-1:0] LOW_LIM  = stl_pkg::CNT_W'(LOW_TOUT_CYC);
  localparam logic [stl_pkg::CNT_W-1:0] IDLE_LIM = stl_pkg::CNT_W'(IDLE_CYC);
  localparam logic [stl_pkg::CNT_W-1:0] STR_LIM  = stl_pkg::CNT_W'(STRETCH_CYC);
  localparam logic [stl_pkg::CNT_W-1:0] HI_LIM   = stl_pkg::CNT_W'(HIGH_MAX_CYC);

  typedef struct packed {
    stl_pkg::stl_state_e         st;
    logic [stl_pkg::CNT_W-1:0]   low_cnt;
    logic [stl_pkg::CNT_W-1:0]   idle_cnt;
    logic [stl_pkg::CNT_W-1:0]   hi_cnt;
    logic [stl_pkg::CNT_W-1:0]   str_cnt;
    logic                        nonstd;
    logic                        stretching;
    logic                        sda_low;
    logic                        abort;
    stl_pkg::stl_stat_s          stat;
  } stl_sup_s;

  stl_pkg::stl_bus_s bus;
  stl_sup_s          state_ff;
  stl_sup_s          nxt_state;

  // saturating increment shared by all timers
  function automatic logic [stl_pkg::CNT_W-1:0] sat_inc(input logic [stl_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + stl_pkg::CNT_W'(1);
  endfunction

  // pins are async to sys_clk; a bus clock of at most 400 kHz gives ample samples
  stl_pin_sync u_sync
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .scl_i     (bus_clock_pin_i),
    .sda_i     (bus_data_pin_i),
    .bus_o     (bus)
  );

  always_comb
  begin
    nxt_state              = state_ff;
    nxt_state.abort        = 1'b0;
    nxt_state.stat.timeout = 1'b0;
    nxt_state.stat.idle_reset = 1'b0;
    nxt_state.nonstd       = nonstandard_bus_ctrl_i;

    // clock low timer, counts only low phases
    nxt_state.low_cnt  = bus.scl ? '0 : sat_inc(state_ff.low_cnt);
    // both lines high timer
    nxt_state.idle_cnt = (bus.scl & bus.sda) ? sat_inc(state_ff.idle_cnt) : '0;
    // clock high timer
    nxt_state.hi_cnt   = bus.scl ? sat_inc(state_ff.hi_cnt) : '0;

    // long high phase means bus free
    nxt_state.stat.high_idle = bus.scl & (state_ff.hi_cnt >= HI_LIM);

    case (state_ff.st)
      stl_pkg::ST_IDLE:
      begin
        nxt_state.str_cnt = '0;
        if (bus.start)
        begin
          nxt_state.st = stl_pkg::ST_ACTIVE;
        end
      end
      stl_pkg::ST_ACTIVE:
      begin
        // stretching only while we actually hold the clock low
        if (state_ff.stretching)
        begin
          nxt_state.str_cnt = sat_inc(state_ff.str_cnt);
        end
        if (bus.stop)
        begin
          nxt_state.st = stl_pkg::ST_IDLE;
        end
        else if (!state_ff.nonstd && state_ff.low_cnt > LOW_LIM)
        begin
          nxt_state.stat.timeout = 1'b1;
          nxt_state.abort        = 1'b1;
          nxt_state.st           = stl_pkg::ST_WAIT;
        end
        else if (!state_ff.nonstd && state_ff.idle_cnt > IDLE_LIM)
        begin
          nxt_state.stat.idle_reset = 1'b1;
          nxt_state.abort           = 1'b1;
          nxt_state.st              = stl_pkg::ST_WAIT;
        end
        else if (bus.start)
        begin
          // repeated start keeps the message budget running
          nxt_state.st = stl_pkg::ST_ACTIVE;
        end
      end
      stl_pkg::ST_WAIT:
      begin
        // partial command dropped; only a fresh start revives us
        nxt_state.str_cnt = '0;
        if (bus.start)
        begin
          nxt_state.st = stl_pkg::ST_ACTIVE;
        end
      end
      default:
      begin
        nxt_state.st = stl_pkg::ST_IDLE;
      end
    endcase

    // stretch granted while budget left; grab only on a low clock
    nxt_state.stat.stretch_allow = (nxt_state.str_cnt < STR_LIM);
    nxt_state.stretching = (nxt_state.st == stl_pkg::ST_ACTIVE) & stretch_req_i & ~bus.scl &
                           (state_ff.stretching | bus.scl_fall) &
                           nxt_state.stat.stretch_allow;
    // data drive released in any state but active
    nxt_state.sda_low   = (nxt_state.st == stl_pkg::ST_ACTIVE) & sda_drive_low_i;
    nxt_state.stat.busy = (nxt_state.st == stl_pkg::ST_ACTIVE);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_ff        <= '0;
      state_ff.st     <= stl_pkg::ST_IDLE;
      state_ff.nonstd <= stl_pkg::NONSTD_RST;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // open-drain: only ever drive low
  assign bus_clock_pin_o      = 1'b0;
  assign bus_clock_pin_oe_n_o = ~state_ff.stretching;
  assign bus_data_pin_o       = 1'b0;
  assign bus_data_pin_oe_n_o  = ~state_ff.sda_low;
  assign xfer_abort_o         = state_ff.abort;
  assign timeout_o            = state_ff.stat.timeout;
  assign idle_reset_o         = state_ff.stat.idle_reset;
  assign bus_idle_o           = state_ff.stat.high_idle;
  assign busy_o               = state_ff.stat.busy;
endmodule

/* verification/stl_bus_supervisor_chk.sv */
// concurrent checks on the timing supervisor ports
`timescale 1ns/1ns
module stl_bus_supervisor_chk
#(
  parameter int unsigned LOW_TOUT_CYC = 200,
  parameter int unsigned IDLE_CYC     = 300,
  parameter int unsigned STRETCH_CYC  = 100,
  parameter int unsigned HIGH_MAX_CYC = 50
)
(
  // clock, reset and bus wires
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic bus_clock_pin_i,
  input  wire logic bus_data_pin_i,
  // control and status
  input  wire logic bus_clock_pin_oe_n_o,
  input  wire logic bus_data_pin_oe_n_o,
  input  wire logic nonstandard_bus_ctrl_i,
  input  wire logic xfer_abort_o,
  input  wire logic timeout_o,
  input  wire logic idle_reset_o,
  input  wire logic bus_idle_o,
  input  wire logic busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  int unsigned low_cnt;
  int unsigned chi_cnt;
  int unsigned both_cnt;
  int unsigned st_cnt;
  logic [2:0]  scl_dly;
  logic [2:0]  sda_dly;
  // timers see the pins three flops late; raw runs would end early and trip the checks
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_dly  <= 3'h7;
      sda_dly  <= 3'h7;
      low_cnt  <= 32'h0;
      chi_cnt  <= 32'h0;
      both_cnt <= 32'h0;
      st_cnt   <= 32'h0;
    end
    else
    begin
      scl_dly  <= {scl_dly[1:0], bus_clock_pin_i};
      sda_dly  <= {sda_dly[1:0], bus_data_pin_i};
      low_cnt  <= scl_dly[2] ? 32'h0 : low_cnt + 32'h1;
      chi_cnt  <= scl_dly[2] ? chi_cnt + 32'h1 : 32'h0;
      both_cnt <= (scl_dly[2] && sda_dly[2]) ? both_cnt + 32'h1 : 32'h0;
      st_cnt   <= !busy_o ? 32'h0 : st_cnt + {31'h0, !bus_clock_pin_oe_n_o};
    end
  end
  AST_TOUT_PULSE: assert property (timeout_o |=> !timeout_o)
    else $error("timeout pulse longer than one cycle");
  AST_TOUT_LATE: assert property (timeout_o |-> low_cnt >= LOW_TOUT_CYC)
    else $error("timeout before the clock low limit");
  AST_TOUT_DROP: assert property (timeout_o |-> ##[0:2] !busy_o)
    else $error("transfer kept after timeout");
  AST_IDLE_LATE: assert property (idle_reset_o |-> both_cnt >= IDLE_CYC)
    else $error("idle reset before the high limit");
  AST_CTRL_OFF: assert property ((timeout_o || idle_reset_o) |-> !$past(nonstandard_bus_ctrl_i, 2))
    else $error("timer event while nonstandard control set");
  AST_STRETCH_CAP: assert property (st_cnt <= STRETCH_CYC + 1)
    else $error("stretch budget exceeded");
  AST_BUS_IDLE: assert property (bus_idle_o |-> chi_cnt >= HIGH_MAX_CYC)
    else $error("bus idle before clock high limit");
  AST_ABORT_FREE: assert property (xfer_abort_o |-> ##[0:2] (bus_data_pin_oe_n_o && bus_clock_pin_oe_n_o))
    else $error("drives held after abort");
  C_TOUT: cover property (timeout_o);
  C_IDLE: cover property (idle_reset_o);
  C_BIDLE: cover property ($rose(bus_idle_o));
  C_STR: cover property (!bus_clock_pin_oe_n_o);
endmodule

/* verification/stl_host_model.sv */
// behavioural host that clocks the two-wire bus
`timescale 1ns/1ns
module stl_host_model
(
  // bench clock and clock wire seen
  input  wire logic sys_clk_i,
  input  wire logic scl_wire_i,
  // open-drain drives, 1 releases the line
  output logic      scl_o,
  output logic      sda_o
);
  localparam int unsigned HALF = 20; // half of the 160 ns bus clock
  // released lines read high through the pull-up
  initial
  begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic hold(input int unsigned n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // data falls while clock high
  task automatic start();
    sda_o = 1'h0;
    hold(HALF);
    scl_o = 1'h0;
    hold(HALF);
  endtask
  // data rises while clock high
  task automatic stop();
    sda_o = 1'h0;
    hold(HALF);
    scl_o = 1'h1;
    hold(HALF);
    sda_o = 1'h1;
    hold(HALF);
  endtask
  // waits out target stretching, bounded so a stuck line cannot hang us
  task automatic send_bit(input logic b);
    int unsigned k;
    sda_o = b;
    hold(HALF);
    scl_o = 1'h1;
    for (k = 0; k < 400 && scl_wire_i !== 1'h1; k++) hold(1);
    hold(HALF);
    scl_o = 1'h0;
  endtask
  // both lines released mid-message, no stop
  task automatic float(input int unsigned n);
    sda_o = 1'h1;
    hold(HALF);
    scl_o = 1'h1;
    hold(n);
  endtask
endmodule

/* verification/stl_bus_supervisor_bench.sv */
// self-checking bench for the bus timing supervisor
`timescale 1ns/1ns
module stl_bus_supervisor_bench;
  localparam int unsigned LT = 200;
  localparam int unsigned IT = 300;
  localparam int unsigned ST = 100;
  localparam int unsigned HM = 50;
  logic sys_clk_i = 1'h0;
  logic reset_n_i = 1'h0;
  logic nonstandard_bus_ctrl_i = 1'h0;
  logic stretch_req_i = 1'h0;
  logic sda_drive_low_i = 1'h0;
  logic host_scl, host_sda, bus_clock_pin_i, bus_data_pin_i;
  logic bus_clock_pin_o, bus_clock_pin_oe_n_o, bus_data_pin_o, bus_data_pin_oe_n_o;
  logic xfer_abort_o, timeout_o, idle_reset_o, bus_idle_o, busy_o;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  int n_tout, n_idle, st_cyc, n_abort;
  // wired-and of host and target drives
  assign bus_clock_pin_i = host_scl & (bus_clock_pin_oe_n_o | bus_clock_pin_o);
  assign bus_data_pin_i = host_sda & (bus_data_pin_oe_n_o | bus_data_pin_o);
  stl_bus_supervisor #(.LOW_TOUT_CYC(LT), .IDLE_CYC(IT), .STRETCH_CYC(ST), .HIGH_MAX_CYC(HM)) dut_u
    (.sys_clk_i, .reset_n_i, .bus_clock_pin_i, .bus_data_pin_i, .bus_clock_pin_o, .bus_clock_pin_oe_n_o,
     .bus_data_pin_o, .bus_data_pin_oe_n_o, .nonstandard_bus_ctrl_i, .stretch_req_i, .sda_drive_low_i,
     .xfer_abort_o, .timeout_o, .idle_reset_o, .bus_idle_o, .busy_o);
  stl_host_model host_u (.sys_clk_i, .scl_wire_i(bus_clock_pin_i), .scl_o(host_scl), .sda_o(host_sda));
  initial
  begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // event counts and hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    n_tout += (timeout_o === 1'h1);
    n_idle += (idle_reset_o === 1'h1);
    st_cyc += (bus_clock_pin_oe_n_o === 1'h0);
    n_abort += (xfer_abort_o === 1'h1);
    if (cyc == 8000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic t_basic();
    host_u.start();
    chk("busy_after_start", 1'h1, busy_o);
    chk("bus_idle_low", 1'h0, bus_idle_o);
    host_u.send_bit(1'h0);
    host_u.stop();
    chk("busy_after_stop", 1'h0, busy_o);
    $display("test basic done");
  endtask
  task automatic t_tout();
    n_tout = 0;
    n_abort = 0;
    host_u.start();
    host_u.hold(LT + 40);
    chk("timeout_once", 1'h1, n_tout == 1);
    chk("abort_once", 1'h1, n_abort == 1);
    chk("busy_after_timeout", 1'h0, busy_o);
    sda_drive_low_i = 1'h1;
    host_u.hold(10);
    chk("data_released", 1'h1, bus_data_pin_oe_n_o);
    sda_drive_low_i = 1'h0;
    host_u.stop();
    $display("test timeout done");
  endtask
  task automatic t_nonstd();
    nonstandard_bus_ctrl_i = 1'h1;
    n_tout = 0;
    n_idle = 0;
    host_u.start();
    host_u.hold(LT + 40);
    chk("busy_kept", 1'h1, busy_o);
    // float inside the message so the idle reset would really fire if not masked
    host_u.float(IT + 40);
    chk("busy_kept_idle", 1'h1, busy_o);
    host_u.stop();
    chk("no_timer_events", 1'h1, n_tout == 0 && n_idle == 0);
    nonstandard_bus_ctrl_i = 1'h0;
    $display("test nonstandard done");
  endtask
  task automatic t_idle();
    host_u.start();
    n_idle = 0;
    host_u.float(IT + 40);
    chk("idle_reset_once", 1'h1, n_idle == 1);
    chk("busy_after_idle", 1'h0, busy_o);
    chk("bus_idle", 1'h1, bus_idle_o);
    $display("test idle done");
  endtask
  task automatic t_stretch();
    host_u.start();
    st_cyc = 0;
    stretch_req_i = 1'h1;
    repeat (4) host_u.send_bit(1'h1);
    stretch_req_i = 1'h0;
    chk("stretch_used", 1'h1, st_cyc > 0);
    chk("stretch_capped", 1'h1, st_cyc == ST);
    host_u.stop();
    $display("test stretch done");
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge sys_clk_i);
    reset_n_i = 1'h1;
    host_u.hold(10);
    t_basic();
    t_tout();
    t_nonstd();
    t_idle();
    t_stretch();
    stop_test();
  end
endmodule
bind stl_bus_supervisor stl_bus_supervisor_chk #(.LOW_TOUT_CYC(LOW_TOUT_CYC), .IDLE_CYC(IDLE_CYC),
  .STRETCH_CYC(STRETCH_CYC), .HIGH_MAX_CYC(HIGH_MAX_CYC)) chk_u (.sys_clk_i, .reset_n_i, .bus_clock_pin_i,
  .bus_data_pin_i, .bus_clock_pin_oe_n_o, .bus_data_pin_oe_n_o, .nonstandard_bus_ctrl_i, .xfer_abort_o,
  .timeout_o, .idle_reset_o, .bus_idle_o, .busy_o);
